// ===== hdl/afi_pkg.sv
// shared constants and carrier types for the 16 x 5 strobe-driven fifo
package afi_pkg;

  localparam int WORD_W = 5;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;

  // timing, in ns or MHz as printed, and the derived cycle counts
  localparam int CLK_PERIOD_NS = 4;
  localparam int VAC_MIN_NS = 7;
  localparam int VAC_CYC = (VAC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] VAC_CYC_LAST = 2'(VAC_CYC - 1);
  localparam int FLUSH_MIN_NS = 40;
  localparam int MAX_STROBE_MHZ = 10;

  // wishbone register map, byte addresses
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 4'h0;
  localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [ADR_W-1:0] OFS_CTRL = 4'h8;
  localparam logic [ADR_W-1:0] OFS_LEVEL = 4'hc;

  // interrupt status bit positions
  localparam int EV_W = 5;
  localparam int EV_FULL = 0;
  localparam int EV_OVERRUN = 1;
  localparam int EV_UNDERRUN = 2;
  localparam int EV_FLUSH = 3;
  localparam int EV_HEAD = 4;
  localparam logic [EV_W-1:0] IRQ_STATUS_RST = 5'h00;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;

  // control and level register fields
  localparam int CTRL_SOFT_FLUSH = 0;
  localparam int LVL_SPACE = 5;
  localparam int LVL_HEAD_VALID = 6;

  typedef struct packed {
    logic load_strobe_first;
    logic load_strobe_second;
    logic [WORD_W-1:0] write_word_in;
    logic unload_strobe;
    logic flush_input_n;
    logic output_enable_n;
  } afi_pin_in_t;

  localparam afi_pin_in_t PIN_IN_RST = '{1'b1, 1'b1, 5'h00, 1'b1, 1'b1, 1'b1};

  typedef struct packed {
    logic space_available;
    logic vacancy_pulse_n;
    logic head_valid;
    logic [WORD_W-1:0] read_word_out;
    logic read_word_oe;
  } afi_pin_out_t;

  typedef enum logic {FETCH_IDLE, FETCH_WAIT} afi_fetch_t;

endpackage : afi_pkg

// ===== hdl/afi_word_mem.sv
// word storage array with registered read data
`timescale 1ns/1ps
module afi_word_mem #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_data_ff;

  // array has no reset; only written words are ever read back
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_ff <= '0;
    end else if (rd_en) begin
      rd_data_ff <= mem_ff[rd_addr];
    end
  end

  assign rd_data = rd_data_ff;

endmodule : afi_word_mem

// ===== hdl/afi_fifo_top.sv
// strobe-driven 16 x 5 fifo with wishbone status and interrupt registers
//
// How it works
// [RULE_01] a word is captured on the rising edge of the toggling load strobe
// [RULE_02] producer holds one load strobe high while pulsing the other
// [RULE_03] unload strobe rests high; its rising edge releases the head word
// [RULE_04] space available is high unless all sixteen locations are occupied
// [RULE_05] vacancy pulse goes low at least 7 ns when a full queue frees a location
// [RULE_06] head valid is high only while head holds data and unload is high
// [RULE_07] head valid is forced low while the unload strobe is low
// [RULE_08] read data always shows the head location
// [RULE_09] read data keeps the polarity of the written data
// [RULE_10] output enable low drives read data; high floats it, rest keeps working
// [RULE_11] falling edge of flush empties the queue and drops head valid
// [RULE_12] flush leaves the read data value unchanged
// [RULE_13] storage holds sixteen five-bit words, moved a whole word at a time
// [RULE_14] write and read sides run independently from dc up to 10 MHz
// [RULE_15] a word written to an empty queue moves to the head without a read
// [RULE_16] producer avoids writing when full; consumer avoids reading when not valid
`timescale 1ns/1ps
module afi_fifo_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire afi_pkg::afi_pin_in_t pins_i,
  output afi_pkg::afi_pin_out_t pins_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [afi_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq
);
  import afi_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  afi_pin_in_t pin_s1_ff;
  afi_pin_in_t pin_s2_ff;
  afi_pin_in_t pin_d_ff;

  // two stages per pin; 250 MHz oversamples 10 MHz strobes many times over
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= PIN_IN_RST;
      pin_s2_ff <= PIN_IN_RST;
      pin_d_ff <= PIN_IN_RST;
    end else begin
      pin_s1_ff <= pins_i;
      pin_s2_ff <= pin_s1_ff; // RULE_14
      pin_d_ff <= pin_s2_ff;
    end
  end

  logic rise_first;
  logic rise_second;
  logic wr_rise;
  logic rd_rise;
  logic pin_flush;
  logic soft_flush_ff;
  logic flush_evt;

  assign rise_first = pin_s2_ff.load_strobe_first & ~pin_d_ff.load_strobe_first;
  assign rise_second = pin_s2_ff.load_strobe_second & ~pin_d_ff.load_strobe_second;
  // partner strobe low acts as inhibit
  assign wr_rise = (rise_first & pin_s2_ff.load_strobe_second)
                 | (rise_second & pin_s2_ff.load_strobe_first); // RULE_01 RULE_02
  assign rd_rise = pin_s2_ff.unload_strobe & ~pin_d_ff.unload_strobe; // RULE_03
  assign pin_flush = ~pin_s2_ff.flush_input_n & pin_d_ff.flush_input_n;
  assign flush_evt = pin_flush | soft_flush_ff; // RULE_11

  ////////////////////////////////////////////////////////////////////////////
  // queue control
  afi_fetch_t fetch_ff;
  logic head_full_ff;
  logic [WORD_W-1:0] head_word_ff;
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] mem_cnt_ff;
  logic [CNT_W-1:0] occupancy_ff;
  logic [CNT_W-1:0] nxt_occupancy;
  logic [WORD_W-1:0] mem_rd_data;
  logic write_ok;
  logic overrun;
  logic release_head;
  logic fetch_go;
  logic nxt_head_full;

  // occupancy counts memory, the word in flight and the head together
  assign write_ok = wr_rise & (occupancy_ff != DEPTH_CNT) & ~flush_evt;
  assign overrun = wr_rise & (occupancy_ff == DEPTH_CNT);
  assign release_head = rd_rise & head_full_ff & ~flush_evt;
  assign fetch_go = (fetch_ff == FETCH_IDLE) & ~head_full_ff & (mem_cnt_ff != '0) & ~flush_evt; // RULE_15
  assign nxt_occupancy = flush_evt ? '0
                       : occupancy_ff + CNT_W'(write_ok) - CNT_W'(release_head);

  afi_word_mem #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH),
    .AW(PTR_W)
  ) u_mem ( // RULE_13
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(write_ok),
    .wr_addr(wr_ptr_ff),
    .wr_data(pin_s2_ff.write_word_in),
    .rd_en(fetch_go),
    .rd_addr(rd_ptr_ff),
    .rd_data(mem_rd_data)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      mem_cnt_ff <= '0;
      occupancy_ff <= '0;
    end else if (flush_evt) begin
      wr_ptr_ff <= '0; // RULE_11
      rd_ptr_ff <= '0;
      mem_cnt_ff <= '0;
      occupancy_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + PTR_W'(write_ok); // RULE_01
      rd_ptr_ff <= rd_ptr_ff + PTR_W'(fetch_go);
      mem_cnt_ff <= mem_cnt_ff + CNT_W'(write_ok) - CNT_W'(fetch_go);
      occupancy_ff <= nxt_occupancy;
    end
  end

  // head word is cleared only by reset: a flush only drops its valid flag
  always_comb begin
    nxt_head_full = head_full_ff;
    if (flush_evt) begin
      nxt_head_full = 1'b0;
    end else if (release_head) begin
      nxt_head_full = 1'b0;
    end else if (fetch_ff == FETCH_WAIT) begin
      nxt_head_full = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_ff <= FETCH_IDLE;
      head_full_ff <= 1'b0;
      head_word_ff <= '0;
    end else begin
      head_full_ff <= nxt_head_full; // RULE_03 RULE_11
      case (fetch_ff)
        FETCH_IDLE: begin
          if (fetch_go) begin
            fetch_ff <= FETCH_WAIT;
          end
        end
        FETCH_WAIT: begin
          fetch_ff <= FETCH_IDLE;
          if (!flush_evt) begin
            head_word_ff <= mem_rd_data; // RULE_08 RULE_09 RULE_12 RULE_15
          end
        end
        default: begin
          fetch_ff <= FETCH_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status pins
  logic space_ff;
  logic vac_n_ff;
  logic [1:0] vac_cnt_ff;
  logic head_valid_ff;
  logic oe_ff;
  logic vac_start;

  assign vac_start = (occupancy_ff == DEPTH_CNT) & (nxt_occupancy != DEPTH_CNT);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      space_ff <= 1'b1;
      head_valid_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      space_ff <= (nxt_occupancy != DEPTH_CNT); // RULE_04
      head_valid_ff <= nxt_head_full & pin_s2_ff.unload_strobe; // RULE_06 RULE_07
      oe_ff <= ~pin_s2_ff.output_enable_n; // RULE_10
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vac_n_ff <= 1'b1;
      vac_cnt_ff <= '0;
    end else if (vac_start) begin
      vac_n_ff <= 1'b0; // RULE_05
      vac_cnt_ff <= VAC_CYC_LAST;
    end else if (vac_cnt_ff != '0) begin
      vac_n_ff <= 1'b0;
      vac_cnt_ff <= vac_cnt_ff - 2'h1;
    end else begin
      vac_n_ff <= 1'b1;
    end
  end

  // the pad ring turns read_word_oe into the three-state drive
  assign pins_o = '{space_ff, vac_n_ff, head_valid_ff, head_word_ff, oe_ff};

  ////////////////////////////////////////////////////////////////////////////
  // wishbone registers and interrupt
  logic ack_ff;
  logic [31:0] dat_ff;
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] mask_ff;
  logic irq_ff;
  logic wb_req;
  logic wb_wr;
  logic [EV_W-1:0] events;
  logic [EV_W-1:0] w1c;
  logic [EV_W-1:0] nxt_status;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // a write commits on the edge at which the master samples ack high
  assign wb_wr = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];
  assign w1c = (wb_wr && wb_adr_i == OFS_IRQ_STATUS) ? wb_dat_i[EV_W-1:0] : '0;

  always_comb begin
    events = '0;
    events[EV_FULL] = space_ff & (nxt_occupancy == DEPTH_CNT);
    events[EV_OVERRUN] = overrun;
    events[EV_UNDERRUN] = rd_rise & ~head_full_ff;
    events[EV_FLUSH] = flush_evt;
    events[EV_HEAD] = ~head_full_ff & nxt_head_full;
  end

  // a new event beats a simultaneous clear
  assign nxt_status = (status_ff & ~w1c) | events;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_ff <= IRQ_STATUS_RST;
      mask_ff <= IRQ_MASK_RST;
      soft_flush_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
      soft_flush_ff <= wb_wr & (wb_adr_i == OFS_CTRL) & wb_dat_i[CTRL_SOFT_FLUSH];
      if (wb_wr && wb_adr_i == OFS_IRQ_MASK) begin
        mask_ff <= wb_dat_i[EV_W-1:0];
      end
    end
  end

  // one wait state; unmapped offsets read zero and ignore writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end else begin
      ack_ff <= wb_req;
      dat_ff <= '0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          OFS_IRQ_STATUS: dat_ff <= 32'(status_ff);
          OFS_IRQ_MASK: dat_ff <= 32'(mask_ff);
          OFS_LEVEL: dat_ff <= 32'({head_valid_ff, space_ff, occupancy_ff});
          default: dat_ff <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign irq = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence full_left_s;
    (occupancy_ff == DEPTH_CNT) ##1 (occupancy_ff != DEPTH_CNT);
  endsequence

  sequence fetch_done_s;
    fetch_go ##1 !flush_evt;
  endsequence

  write_capture_a: assert property ( // RULE_01
    (wr_rise && occupancy_ff != DEPTH_CNT && !flush_evt && !release_head)
      |=> occupancy_ff == $past(occupancy_ff) + 5'h01)
    else $error("accepted write did not raise occupancy");

  head_release_a: assert property ( // RULE_03
    (rd_rise && head_full_ff && !flush_evt && !write_ok) |=> !head_full_ff && occupancy_ff == $past(occupancy_ff) - 5'h01)
    else $error("unload edge did not release head");

  space_flag_a: assert property ( // RULE_04
    space_ff == (occupancy_ff != DEPTH_CNT))
    else $error("space available disagrees with occupancy");

  vacancy_pulse_a: assert property ( // RULE_05
    full_left_s |-> !vac_n_ff [*2])
    else $error("vacancy pulse too short or missing");

  head_valid_a: assert property ( // RULE_06
    head_valid_ff == (head_full_ff && pin_d_ff.unload_strobe))
    else $error("head valid does not match head and unload");

  unload_low_a: assert property ( // RULE_07
    !pin_d_ff.unload_strobe |-> !head_valid_ff)
    else $error("head valid high while unload low");

  head_data_a: assert property ( // RULE_08 RULE_09
    $rose(head_full_ff) |-> head_word_ff == $past(mem_rd_data))
    else $error("head word differs from stored word");

  output_drive_a: assert property ( // RULE_10
    oe_ff == !pin_d_ff.output_enable_n)
    else $error("read data enable wrong");

  flush_clear_a: assert property ( // RULE_11
    flush_evt |=> occupancy_ff == '0 && !head_full_ff && !head_valid_ff && mem_cnt_ff == '0)
    else $error("flush did not empty the queue");

  flush_keep_a: assert property ( // RULE_12
    flush_evt |=> $stable(head_word_ff))
    else $error("flush changed read data");

  fall_through_a: assert property ( // RULE_15
    fetch_done_s |=> head_full_ff)
    else $error("stored word did not reach head");

endmodule : afi_fifo_top

// ===== testbench/afi_pin_partner.sv
// producer and consumer model driving the fifo pins
`timescale 1ns/1ps
module afi_pin_partner (
  input wire logic sys_clk,
  output afi_pkg::afi_pin_in_t pins,
  input wire afi_pkg::afi_pin_out_t pins_o
);
  import afi_pkg::*;
  // 13 cycle halves keep every strobe below 10 MHz
  localparam int HALF = 13;
  initial pins = PIN_IN_RST;
  ////////////////////////////////////////////////////////////
  task automatic load(input logic [WORD_W-1:0] d, input logic second, input logic ovr);
    if (!ovr && !pins_o.space_available) return;
    @(posedge sys_clk);
    pins.write_word_in <= d;
    if (second) pins.load_strobe_second <= 1'b0;
    else pins.load_strobe_first <= 1'b0;
    repeat (HALF) @(posedge sys_clk);
    if (second) pins.load_strobe_second <= 1'b1;
    else pins.load_strobe_first <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
    // hold time is over: stale data shows its inverse
    pins.write_word_in <= ~d;
  endtask : load
  task automatic inhibit(input logic on);
    @(posedge sys_clk);
    pins.load_strobe_first <= !on;
    repeat (HALF) @(posedge sys_clk);
  endtask : inhibit
  task automatic unload(input logic ovr);
    if (!ovr && !pins_o.head_valid) return;
    @(posedge sys_clk);
    pins.unload_strobe <= 1'b0;
    repeat (HALF) @(posedge sys_clk);
    pins.unload_strobe <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
  endtask : unload
  task automatic flush();
    @(posedge sys_clk);
    pins.flush_input_n <= 1'b0;
    repeat (HALF) @(posedge sys_clk);
    pins.flush_input_n <= 1'b1;
    repeat (HALF) @(posedge sys_clk);
  endtask : flush
  task automatic set_oe(input logic on);
    @(posedge sys_clk);
    pins.output_enable_n <= !on;
  endtask : set_oe
endmodule : afi_pin_partner

// ===== testbench/tb_top.sv
// self-checking bench for the strobe fifo: pins, registers, interrupt
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  import afi_pkg::*;
  logic sys_clk, rst, cyc, stb, we, ack, irq, lane0;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, seed;
  logic [WORD_W-1:0] w;
  logic [WORD_W-1:0] exp_q[$];
  afi_pin_in_t pins_i;
  afi_pin_out_t pins_o;
  int err_count, samples_checked, vac_len, ul_low;

  afi_fifo_top i_dut (.sys_clk(sys_clk), .rst(rst), .pins_i(pins_i), .pins_o(pins_o),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq));
  afi_pin_partner i_prt (.sys_clk(sys_clk), .pins(pins_i), .pins_o(pins_o));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : nxt_rand
  function automatic logic [31:0] lvl(input int n);
    return 32'(n) | (n < DEPTH ? 32'h20 : 32'h0) | (n > 0 ? 32'h40 : 32'h0);
  endfunction : lvl
  task automatic wbx(input logic wr, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    seed = nxt_rand(seed);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    // unused upper data bits and lanes carry random noise
    wdat <= {seed[31:EV_W], d[EV_W-1:0]};
    sel <= {seed[3:1], lane0};
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wbx
  task automatic rchk(input logic [ADR_W-1:0] a, input logic [31:0] e);
    wbx(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rchk
  task automatic hv_wait(input logic v);
    int n;
    n = 0;
    while (pins_o.head_valid !== v && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(pins_o.head_valid, v)
  endtask : hv_wait
  task automatic put(input logic ovr);
    logic [WORD_W-1:0] d;
    seed = nxt_rand(seed);
    d = seed[WORD_W-1:0];
    if (exp_q.size() < DEPTH) exp_q.push_back(d);
    i_prt.load(d, seed[8], ovr);
  endtask : put
  task automatic get();
    hv_wait(1'b1);
    `CHK(pins_o.read_word_out, exp_q[0])
    void'(exp_q.pop_front());
    i_prt.unload(1'b0);
  endtask : get
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // unload held low must keep head valid down; vacancy pulse is two cycles
  always @(posedge sys_clk) begin
    ul_low <= (pins_i.unload_strobe === 1'b0) ? ul_low + 1 : 0;
    if (ul_low > 4) `CHK(pins_o.head_valid, 1'b0)
    if (pins_o.vacancy_pulse_n === 1'b0 && !rst) vac_len <= vac_len + 1;
    else if (vac_len != 0) begin
      `CHK(vac_len, 2)
      vac_len <= 0;
    end
  end
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    {rst, cyc, stb, we, adr, sel, wdat} = {1'b1, 43'h0};
    {err_count, samples_checked, vac_len, ul_low} = '0;
    seed = 32'haa1f;
    lane0 = 1'b1;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(pins_o, 9'h180)
    rchk(OFS_IRQ_STATUS, 32'h0);
    rchk(OFS_LEVEL, lvl(0));
    rchk(4'h2, 32'h0);
    wbx(1'b1, OFS_IRQ_MASK, 32'h1f);
    rchk(OFS_IRQ_MASK, 32'h1f);
    // a write without its low lane must be ignored
    lane0 = 1'b0;
    wbx(1'b1, OFS_IRQ_MASK, 32'h0);
    lane0 = 1'b1;
    rchk(OFS_IRQ_MASK, 32'h1f);
    i_prt.set_oe(1'b1);
    repeat (6) @(posedge sys_clk);
    `CHK(pins_o.read_word_oe, 1'b1)
    i_prt.inhibit(1'b1);
    i_prt.load(5'h0a, 1'b1, 1'b0);
    rchk(OFS_LEVEL, lvl(0));
    exp_q.push_back(5'h15);
    i_prt.inhibit(1'b0);
    hv_wait(1'b1);
    `CHK(pins_o.read_word_out, exp_q[0])
    rchk(OFS_IRQ_STATUS, 32'h10);
    `CHK(irq, 1'b1)
    wbx(1'b1, OFS_IRQ_STATUS, 32'h1f);
    rchk(OFS_IRQ_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    repeat (15) put(1'b0);
    `CHK(pins_o.space_available, 1'b0)
    rchk(OFS_LEVEL, lvl(16));
    put(1'b1);
    rchk(OFS_IRQ_STATUS, 32'h3);
    while (exp_q.size() > 0) begin
      get();
      if (exp_q.size() == 15) `CHK(pins_o.space_available, 1'b1)
    end
    hv_wait(1'b0);
    i_prt.unload(1'b1);
    wbx(1'b0, OFS_IRQ_STATUS, 32'h0);
    `CHK(q[EV_UNDERRUN], 1'b1)
    repeat (3) put(1'b0);
    hv_wait(1'b1);
    w = exp_q[0];
    i_prt.flush();
    exp_q.delete();
    `CHK(pins_o.head_valid, 1'b0)
    `CHK(pins_o.read_word_out, w)
    rchk(OFS_LEVEL, lvl(0));
    put(1'b0);
    hv_wait(1'b1);
    `CHK(pins_o.read_word_out, exp_q[0])
    i_prt.set_oe(1'b0);
    repeat (6) @(posedge sys_clk);
    `CHK(pins_o.read_word_oe, 1'b0)
    `CHK(pins_o.head_valid, 1'b1)
    wbx(1'b1, OFS_CTRL, 32'h1);
    exp_q.delete();
    rchk(OFS_LEVEL, lvl(0));
    rchk(OFS_CTRL, 32'h0);
    wbx(1'b1, OFS_IRQ_MASK, 32'h0);
    rchk(OFS_IRQ_MASK, 32'h0);
    `CHK(irq, 1'b0)
    give_verdict();
  end
endmodule : tb_top
